// ==== include/serial_port_pkg.sv ====
// Constants, types and decode helpers for the serial port control block.
// Assumes one system clock; every user refers to names as serial_port_pkg::name.
//
// What this block does
// R01 - Slave SPI byte arriving while buffer unread sets overflow; new byte dropped.
// R02 - Overflow condition only raised in SPI slave modes.
// R03 - Slave software reads buffer after every transfer to avoid overflow.
// R04 - Master modes never set overflow; transfers start on buffer writes.
// R05 - Overflow stays set until software clears it; hardware never clears.
// R06 - Enable in SPI routes clock, data out, data in, select to pins.
// R07 - Enable clear disables port and returns pins to general I/O.
// R08 - Enable in I2C makes port logic drive SDA and SCL pins; here SDA is never driven, and SCL only by the slave-mode stretch.
// R09 - Software sets each pin direction correctly whenever port is enabled.
// R10 - SPI clock polarity bit: one idles high, zero idles low.
// R11 - I2C slave holds SCL low while release bit zero; releases at one.
// R12 - Codes 1111 and 1110 select I2C slave with start/stop interrupts; the block raises no start/stop events, only overflow and receive.
// R13 - Software never uses reload 0, 1 or 2 in I2C master.
// R14 - Software never uses reload 0 in SPI reload master; uses 0000.
// R15 - 1010 SPI master, 1000 I2C master, clock = osc/(4*(reload+1)); only 1010 gets this clock here, 1000 generates none.
// R16 - 1011 firmware I2C master, slave idle; 0111/0110 I2C slave 10/7-bit.

package serial_port_pkg;

	// ********************************
	// Register map and fields
	// ********************************
	localparam logic [2:0] ADDR_CON1 = 3'h0;
	localparam logic [2:0] ADDR_BUF = 3'h1;
	localparam logic [2:0] ADDR_STAT = 3'h2;
	localparam logic [2:0] ADDR_MASK = 3'h3;
	localparam logic [2:0] ADDR_RELOAD = 3'h4;
	localparam int OVF_BIT = 6;
	localparam int EN_BIT = 5;
	localparam int CKP_BIT = 4;
	localparam int EVT_OVF = 0;
	localparam int EVT_RX = 1;
	localparam logic [7:0] CON1_RESET = 8'h00;
	localparam logic [7:0] RELOAD_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	// Every output enable high, no function selected, clock at the low idle level
	localparam logic [9:0] PINS_RESET = 10'h154;

	// ********************************
	// Clock divider half periods, in system clocks
	// ********************************
	localparam logic [9:0] HALF_DIV4 = 10'h002;
	localparam logic [9:0] HALF_DIV16 = 10'h008;
	localparam logic [9:0] HALF_DIV64 = 10'h020;

	typedef enum logic [3:0] {
		SPI_M_DIV4 = 4'b0000,
		SPI_M_DIV16 = 4'b0001,
		SPI_M_DIV64 = 4'b0010,
		SPI_M_TMR = 4'b0011,
		SPI_S_SEL = 4'b0100,
		SPI_S_NOSEL = 4'b0101,
		I2C_S_7 = 4'b0110,
		I2C_S_10 = 4'b0111,
		I2C_M_RELOAD = 4'b1000,
		RSV_9 = 4'b1001,
		SPI_M_RELOAD = 4'b1010,
		I2C_M_FW = 4'b1011,
		RSV_C = 4'b1100,
		RSV_D = 4'b1101,
		I2C_S_7_SP = 4'b1110,
		I2C_S_10_SP = 4'b1111
	} port_mode_type;

	typedef enum logic [0:0] {
		LINK_IDLE = 1'b0,
		LINK_RUN = 1'b1
	} link_state_type;

	typedef struct packed {
		logic collide;
		logic ovf;
		logic en;
		logic ckp;
		port_mode_type mode;
	} con1_type;

	typedef struct packed {
		logic sckOut;
		logic sckOe_n;
		logic sdoOut;
		logic sdoOe_n;
		logic sclOut;
		logic sclOe_n;
		logic sdaOut;
		logic sdaOe_n;
		logic spiSel;
		logic i2cSel;
	} pin_out_type;

	function automatic logic isSpiMaster(port_mode_type m);
		return m inside {SPI_M_DIV4, SPI_M_DIV16, SPI_M_DIV64, SPI_M_TMR, SPI_M_RELOAD};
	endfunction

	function automatic logic isSpiSlave(port_mode_type m);
		return m inside {SPI_S_SEL, SPI_S_NOSEL};
	endfunction

	function automatic logic isI2cSlave(port_mode_type m);
		return m inside {I2C_S_7, I2C_S_10, I2C_S_7_SP, I2C_S_10_SP};
	endfunction

	function automatic logic isI2c(port_mode_type m);
		return isI2cSlave(m) || m inside {I2C_M_RELOAD, I2C_M_FW};
	endfunction

	function automatic logic [9:0] halfPeriod(port_mode_type m, logic [7:0] reload);
		unique case (m)
			SPI_M_DIV4: return HALF_DIV4;
			SPI_M_DIV16: return HALF_DIV16;
			SPI_M_DIV64: return HALF_DIV64;
			default: return {1'b0, reload, 1'b0} + 10'h002;
		endcase
	endfunction

endpackage

// ==== verilog/sync_two_flop.sv ====
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level from outside the mclk domain.
`timescale 1ns/1ps
`default_nettype none

module sync_two_flop #(
	parameter int WIDTH = 3
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic ce,
	// Levels
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg <= '0;
			q <= '0;
		end else if (ce) begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end

endmodule // sync_two_flop

`default_nettype wire

// ==== verilog/serial_port_control_one.sv ====
// Control register one of the synchronous serial port, with SPI shifter and pin steering.
// Assumes pins arrive asynchronously; register port runs on mclk with one-cycle read data.
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module serial_port_control_one (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic ce,
	// Register port
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Link pins and timer
	input wire logic sckIn,
	input wire logic sdiIn,
	input wire logic ssIn_n,
	input wire logic timerMatch,
	output serial_port_pkg::pin_out_type pins,
	// Interrupt
	output logic irq
);

	// ********************************
	// Declarations
	// ********************************
	serial_port_pkg::con1_type con1Reg, con1Next;
	logic [7:0] bufReg, bufNext, statReg, statNext, maskReg, maskNext, reloadReg, reloadNext;
	logic [7:0] rdataNext, shiftReg, shiftNext;
	logic bufFullReg, bufFullNext, irqNext, sampReg, sampNext, sckPrevReg;
	logic [2:0] bitCntReg, bitCntNext;
	logic [9:0] divCntReg, divNext;
	logic sckLvlReg, sckLvlNext, lead, trail, tick, linkDone, full, ovfEvt;
	logic bufRead, bufWrite, sckS, sdiS, ssS_n, slaveMode;
	logic [7:0] linkByte;
	serial_port_pkg::link_state_type stateReg, stateNext;
	serial_port_pkg::pin_out_type pinsNext;

	// Pins cross in through two flops; edges are found on the synchronised copy only
	sync_two_flop #(.WIDTH(3)) pinSync (
		.mclk(mclk),
		.arst_n(arst_n),
		.ce(ce),
		.d({sckIn, sdiIn, ssIn_n}),
		.q({sckS, sdiS, ssS_n})
	);

	assign bufRead = rd && addr == serial_port_pkg::ADDR_BUF;
	assign bufWrite = wr && addr == serial_port_pkg::ADDR_BUF;
	assign slaveMode = serial_port_pkg::isSpiSlave(con1Reg.mode);

	// ********************************
	// Shift engine
	// ********************************
	always_comb begin
		shiftNext = shiftReg;
		sampNext = sampReg;
		bitCntNext = bitCntReg;
		stateNext = stateReg;
		divNext = divCntReg;
		sckLvlNext = sckLvlReg;
		lead = 1'b0;
		trail = 1'b0;
		tick = 1'b0;
		linkDone = 1'b0;
		if (!con1Reg.en) begin
			stateNext = serial_port_pkg::LINK_IDLE;
			bitCntNext = 3'h0;
			divNext = 10'h000;
			sckLvlNext = con1Reg.ckp; // [R10]
		end else if (serial_port_pkg::isSpiMaster(con1Reg.mode)) begin
			if (stateReg == serial_port_pkg::LINK_IDLE) begin
				sckLvlNext = con1Reg.ckp; // [R10]
				// Only a buffer write starts a master transfer [R04]
				if (bufWrite) begin
					shiftNext = wdata;
					stateNext = serial_port_pkg::LINK_RUN;
					divNext = 10'h000;
					bitCntNext = 3'h0;
				end
			end else begin
				// Timer mode halves the match rate; others divide the oscillator [R15]
				if (con1Reg.mode == serial_port_pkg::SPI_M_TMR) begin
					tick = timerMatch;
				end else begin
					tick = divCntReg == serial_port_pkg::halfPeriod(con1Reg.mode, reloadReg) - 10'h001;
					divNext = tick ? 10'h000 : divCntReg + 10'h001;
				end
				if (tick) begin
					sckLvlNext = ~sckLvlReg;
					lead = sckLvlReg == con1Reg.ckp;
					trail = !lead;
				end
			end
		end else if (slaveMode) begin
			if (con1Reg.mode == serial_port_pkg::SPI_S_SEL && ssS_n) begin
				bitCntNext = 3'h0;
			end else begin
				lead = sckS != sckPrevReg && sckPrevReg == con1Reg.ckp;
				trail = sckS != sckPrevReg && sckPrevReg != con1Reg.ckp;
			end
			// Data for the next slave byte may only be loaded between bytes
			if (bufWrite && bitCntReg == 3'h0) begin
				shiftNext = wdata;
			end
		end
		if (lead) begin
			sampNext = sdiS;
		end
		if (trail) begin
			shiftNext = {shiftReg[6:0], sampReg};
			bitCntNext = bitCntReg + 3'h1;
			if (bitCntReg == 3'h7) begin
				linkDone = 1'b1;
				stateNext = serial_port_pkg::LINK_IDLE;
			end
		end
	end

	assign linkByte = {shiftReg[6:0], sampReg};

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			shiftReg <= 8'h00;
			sampReg <= 1'b0;
			bitCntReg <= 3'h0;
			stateReg <= serial_port_pkg::LINK_IDLE;
			divCntReg <= 10'h000;
			sckLvlReg <= 1'b0;
			sckPrevReg <= 1'b0;
		end else if (ce) begin
			shiftReg <= shiftNext;
			sampReg <= sampNext;
			bitCntReg <= bitCntNext;
			stateReg <= stateNext;
			divCntReg <= divNext;
			sckLvlReg <= sckLvlNext;
			sckPrevReg <= sckS;
		end
	end

	// ********************************
	// Registers and interrupt
	// ********************************
	always_comb begin
		con1Next = con1Reg;
		bufNext = bufReg;
		maskNext = maskReg;
		reloadNext = reloadReg;
		rdataNext = 8'h00;
		if (wr && addr == serial_port_pkg::ADDR_CON1) begin
			con1Next.en = wdata[serial_port_pkg::EN_BIT];
			con1Next.ckp = wdata[serial_port_pkg::CKP_BIT];
			con1Next.mode = serial_port_pkg::port_mode_type'(wdata[3:0]);
			// Writing zero clears the flag; writing one leaves it [R05]
			if (!wdata[serial_port_pkg::OVF_BIT]) begin
				con1Next.ovf = 1'b0;
			end
		end
		if (wr && addr == serial_port_pkg::ADDR_MASK) begin
			maskNext = wdata;
		end
		if (wr && addr == serial_port_pkg::ADDR_RELOAD) begin
			reloadNext = wdata;
		end
		// A read in this very cycle counts as emptying the buffer
		full = bufFullReg && !bufRead;
		bufFullNext = full;
		ovfEvt = linkDone && full && slaveMode; // [R01] [R02]
		if (linkDone && !ovfEvt) begin
			bufNext = linkByte;
			bufFullNext = 1'b1;
		end
		if (ovfEvt) begin
			con1Next.ovf = 1'b1; // [R01] [R05]
		end
		statNext = statReg;
		if (wr && addr == serial_port_pkg::ADDR_STAT) begin
			statNext = statReg & ~wdata;
		end
		statNext[serial_port_pkg::EVT_OVF] = statNext[serial_port_pkg::EVT_OVF] | ovfEvt;
		statNext[serial_port_pkg::EVT_RX] = statNext[serial_port_pkg::EVT_RX] | (linkDone && !ovfEvt);
		if (rd) begin
			unique case (addr)
				serial_port_pkg::ADDR_CON1: rdataNext = con1Reg;
				serial_port_pkg::ADDR_BUF: rdataNext = bufReg;
				serial_port_pkg::ADDR_STAT: rdataNext = statReg;
				serial_port_pkg::ADDR_MASK: rdataNext = maskReg;
				serial_port_pkg::ADDR_RELOAD: rdataNext = reloadReg;
				default: rdataNext = 8'h00;
			endcase
		end
		irqNext = |(statNext & maskNext);
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			con1Reg <= serial_port_pkg::CON1_RESET;
			bufReg <= 8'h00;
			bufFullReg <= 1'b0;
			statReg <= 8'h00;
			maskReg <= serial_port_pkg::MASK_RESET;
			reloadReg <= serial_port_pkg::RELOAD_RESET;
			rdata <= 8'h00;
			irq <= 1'b0;
		end else if (ce) begin
			con1Reg <= con1Next;
			bufReg <= bufNext;
			bufFullReg <= bufFullNext;
			statReg <= statNext;
			maskReg <= maskNext;
			reloadReg <= reloadNext;
			rdata <= rdataNext;
			irq <= irqNext;
		end
	end

	// ********************************
	// Pin steering
	// ********************************
	always_comb begin
		pinsNext = '0;
		pinsNext.sckOe_n = 1'b1;
		pinsNext.sdoOe_n = 1'b1;
		pinsNext.sclOe_n = 1'b1;
		pinsNext.sdaOe_n = 1'b1;
		pinsNext.sckOut = con1Reg.ckp;
		if (con1Reg.en) begin
			if (serial_port_pkg::isSpiMaster(con1Reg.mode) || slaveMode) begin
				pinsNext.spiSel = 1'b1; // [R06]
				pinsNext.sdoOut = shiftNext[7];
				pinsNext.sdoOe_n = con1Reg.mode == serial_port_pkg::SPI_S_SEL && ssS_n;
				if (!slaveMode) begin
					pinsNext.sckOut = sckLvlNext; // [R10]
					pinsNext.sckOe_n = 1'b0;
				end
			end else if (serial_port_pkg::isI2c(con1Reg.mode)) begin
				pinsNext.i2cSel = 1'b1; // [R08] [R12] [R16]
				// Slave modes stretch SCL; firmware master leaves slave logic idle [R16]
				if (serial_port_pkg::isI2cSlave(con1Reg.mode)) begin
					pinsNext.sclOe_n = con1Reg.ckp; // [R11]
				end
			end
		end
		// Cleared enable leaves every pin released to general I/O [R07]
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			// Reset must not drive any pin; same as a disabled port [R07]
			pins <= serial_port_pkg::PINS_RESET;
		end else if (ce) begin
			pins <= pinsNext;
		end
	end

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	sequence slaveOverrun;
		ce && linkDone && bufFullReg && !bufRead && slaveMode;
	endsequence

	sequence masterIdle;
		ce && con1Reg.en && serial_port_pkg::isSpiMaster(con1Reg.mode) && stateReg == serial_port_pkg::LINK_IDLE;
	endsequence

	overflow_set_a: assert property (slaveOverrun |=> con1Reg.ovf && statReg[serial_port_pkg::EVT_OVF]) // [R01]
		else $error("overrun did not set overflow");
	byte_discard_a: assert property (slaveOverrun |=> bufReg == $past(bufReg) && bufFullReg) // [R01]
		else $error("overrun byte overwrote buffer");
	slave_only_a: assert property ($rose(con1Reg.ovf) |-> $past(slaveMode)) // [R02]
		else $error("overflow raised outside slave mode");
	master_no_ovf_a: assert property (ce && linkDone && !slaveMode |=> !$rose(con1Reg.ovf)) // [R04]
		else $error("master transfer set overflow");
	master_load_a: assert property (ce && linkDone && !slaveMode |=> bufReg == $past(linkByte) && statReg[serial_port_pkg::EVT_RX]) // [R04]
		else $error("master byte not loaded");
	ovf_event_sticky_a: assert property (ce && statReg[serial_port_pkg::EVT_OVF] && !(wr && addr == serial_port_pkg::ADDR_STAT && wdata[serial_port_pkg::EVT_OVF]) |=> statReg[serial_port_pkg::EVT_OVF]) // [R05]
		else $error("overflow event cleared without software");
	ovf_sticky_a: assert property (ce && con1Reg.ovf && !(wr && addr == serial_port_pkg::ADDR_CON1) |=> con1Reg.ovf) // [R05]
		else $error("overflow cleared without software");
	pins_release_a: assert property (ce && !con1Reg.en |=> pins.sckOe_n && pins.sdoOe_n && pins.sclOe_n && !pins.spiSel && !pins.i2cSel) // [R07]
		else $error("pins driven while disabled");
	spi_pins_a: assert property (masterIdle |=> !pins.sckOe_n && !pins.sdoOe_n && pins.spiSel) // [R06]
		else $error("master pins not routed");
	idle_level_a: assert property (masterIdle ##1 masterIdle |-> pins.sckOut == $past(con1Reg.ckp)) // [R10]
		else $error("clock idle level wrong");
	i2c_drive_a: assert property (ce && con1Reg.en && serial_port_pkg::isI2c(con1Reg.mode) |=> pins.i2cSel && !pins.spiSel) // [R08]
		else $error("i2c pins not routed");
	clock_stretch_a: assert property (ce && con1Reg.en && serial_port_pkg::isI2cSlave(con1Reg.mode) |=> pins.sclOe_n == $past(con1Reg.ckp)) // [R11]
		else $error("scl stretch wrong");

endmodule // serial_port_control_one

`default_nettype wire

// ==== test/spi_peer.sv ====
// External SPI peer: a master that clocks bytes in, and a slave that answers the port.
// Assumes an idle-low link clock, leading edge samples and trailing edge shifts.
`timescale 1ns/1ps
`default_nettype none

module spi_peer (
	// From the port
	input wire logic sckOut,
	input wire logic sdoOut,
	// To the port
	output logic sckIn,
	output logic sdiIn,
	output logic ssIn_n
);
	logic [7:0] txByte;
	logic [7:0] rxByte;
	logic slaveOn;
	int cnt;

	initial begin
		sckIn = 1'b0;
		sdiIn = 1'b0;
		ssIn_n = 1'b1;
		slaveOn = 1'b0;
		rxByte = 8'h00;
	end

	// ************************
	// Master role, 80 ns clock only inside the frame
	// ************************
	task automatic sendByte(input logic [7:0] b);
		// Keep link edges off the system clock edges
		#1;
		for (int i = 7; i >= 0; i--) begin
			sdiIn = b[i];
			#40 sckIn = 1'b1;
			#40 sckIn = 1'b0;
		end
		// Released line must not look like a held bit
		sdiIn = ~sdiIn;
	endtask

	// ************************
	// Slave role, MSB ready before the first leading edge
	// ************************
	task automatic loadSlave(input logic [7:0] b);
		txByte = b;
		sdiIn = b[7];
		cnt = 0;
		slaveOn = 1'b1;
	endtask

	always @(posedge sckOut) begin
		if (slaveOn) begin
			rxByte = {rxByte[6:0], sdoOut};
		end
	end

	always @(negedge sckOut) begin
		if (slaveOn) begin
			txByte = {txByte[6:0], 1'b0};
			cnt++;
			slaveOn = (cnt < 8);
			sdiIn = slaveOn ? txByte[7] : ~sdiIn;
		end
	end
endmodule // spi_peer
`default_nettype wire

// ==== test/serial_port_control_one_bench.sv ====
// Self-checking bench for the serial port control register block.
// Assumes the package and spi_peer are compiled first; reads are checked from a queue.
`timescale 1ns/1ps
`default_nettype none

module serial_port_control_one_bench;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic ce = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic timerMatch = 1'b0;
	logic [7:0] rdata;
	logic irq;
	logic sckIn;
	logic sdiIn;
	logic ssIn_n;
	serial_port_pkg::pin_out_type pins;
	logic [7:0] expQ[$];
	logic rdSeen = 1'b0;
	logic sckLast = 1'b0;
	logic [31:0] seed = 32'h7b61;
	int errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	int gap = 0;
	int togs = 0;
	int halfExp = 0;
	int tmrCnt = 0;
	// Control byte, pin mask, expected pins
	logic [27:0] pinTab [13] = '{{8'h30, 10'h303, 10'h202}, {8'h20, 10'h303, 10'h002},
		{8'h26, 10'h033, 10'h001}, {8'h36, 10'h033, 10'h011}, {8'h2f, 10'h033, 10'h001},
		{8'h3e, 10'h033, 10'h011}, {8'h37, 10'h033, 10'h011}, {8'h28, 10'h013, 10'h011},
		{8'h3b, 10'h013, 10'h011}, {8'h25, 10'h143, 10'h102}, {8'h29, 10'h3ff, 10'h154},
		{8'h24, 10'h143, 10'h142}, {8'h10, 10'h3ff, 10'h354}};
	logic [7:0] mModes [4] = '{8'h21, 8'h22, 8'h2a, 8'h23};
	int mHalf [4] = '{8, 32, 8, 6};

	serial_port_control_one i_serial_port_control_one (.mclk(mclk), .arst_n(arst_n), .ce(ce),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sckIn(sckIn), .sdiIn(sdiIn),
		.ssIn_n(ssIn_n), .timerMatch(timerMatch), .pins(pins), .irq(irq));
	spi_peer i_spi_peer (.sckOut(pins.sckOut), .sdoOut(pins.sdoOut), .sckIn(sckIn), .sdiIn(sdiIn),
		.ssIn_n(ssIn_n));

	// ************************
	// Helpers
	// ************************
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("errors=%0d cmp_count=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Write when w is high, else read and note d as expected; strobes stay up back to back
	task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
		wr <= w;
		rd <= ~w;
		addr <= a;
		wdata <= d;
		if (!w) begin
			expQ.push_back(d);
		end
		@(posedge mclk);
	endtask

	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge mclk);
	endtask

	task automatic waitIrq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		check(irq, 1'b1);
	endtask

	// ************************
	// Clock, timeout and watchers
	// ************************
	always #2 mclk = ~mclk;

	always @(posedge mclk) begin
		cycles++;
		if (cycles > 10000) begin
			errors++;
			summarize();
		end
		rdSeen <= rd && ce;
		if (rdSeen) begin
			check(rdata, expQ.pop_front());
		end
		timerMatch <= (tmrCnt == 5);
		tmrCnt = (tmrCnt == 5) ? 0 : tmrCnt + 1;
		sckLast <= pins.sckOut;
		if (pins.sckOut !== sckLast) begin
			if (togs > 0 && halfExp > 0) begin
				check(gap, halfExp);
			end
			togs++;
			gap = 1;
		end else begin
			gap++;
		end
	end

	// ************************
	// Main sequence
	// ************************
	initial begin
		logic [7:0] b;
		logic [7:0] p;
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		check(pins, 10'h154);
		@(posedge mclk);
		bus(1'b1, 3'h6, 8'hff);
		for (int a = 0; a < 7; a++) begin
			bus(1'b0, a[2:0], 8'h00);
		end
		for (int i = 0; i < 13; i++) begin
			bus(1'b1, serial_port_pkg::ADDR_CON1, pinTab[i][27:20]);
			bus(1'b0, serial_port_pkg::ADDR_CON1, pinTab[i][27:20]);
			idle(3);
			check(pins & pinTab[i][19:10], pinTab[i][9:0]);
		end
		// Strobes are ignored while the clock enable is low
		ce <= 1'b0;
		bus(1'b1, serial_port_pkg::ADDR_CON1, 8'h2f);
		ce <= 1'b1;
		bus(1'b0, serial_port_pkg::ADDR_CON1, 8'h10);
		bus(1'b1, serial_port_pkg::ADDR_RELOAD, 8'h03);
		bus(1'b1, serial_port_pkg::ADDR_MASK, 8'h02);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, serial_port_pkg::ADDR_CON1, mModes[i]);
			idle(4);
			for (int k = 0; k < 2; k++) begin
				b = rnd();
				p = rnd();
				i_spi_peer.loadSlave(p);
				togs = 0;
				halfExp = mHalf[i];
				bus(1'b1, serial_port_pkg::ADDR_BUF, b);
				idle(1);
				waitIrq();
				idle(3);
				halfExp = 0;
				check(togs, 16);
				check(i_spi_peer.rxByte, b);
				bus(1'b1, serial_port_pkg::ADDR_STAT, 8'h02);
				idle(2);
				check(irq, 1'b0);
			end
			// Buffer left unread across two bytes, still no overflow in master
			bus(1'b0, serial_port_pkg::ADDR_CON1, mModes[i]);
			bus(1'b0, serial_port_pkg::ADDR_BUF, p);
		end
		bus(1'b1, serial_port_pkg::ADDR_CON1, 8'h25);
		idle(4);
		b = rnd();
		p = rnd();
		i_spi_peer.sendByte(b);
		waitIrq();
		bus(1'b1, serial_port_pkg::ADDR_MASK, 8'h01);
		idle(2);
		check(irq, 1'b0);
		i_spi_peer.sendByte(p);
		waitIrq();
		bus(1'b0, serial_port_pkg::ADDR_CON1, 8'h65);
		bus(1'b0, serial_port_pkg::ADDR_STAT, 8'h03);
		bus(1'b0, serial_port_pkg::ADDR_BUF, b);
		bus(1'b0, serial_port_pkg::ADDR_CON1, 8'h65);
		bus(1'b1, serial_port_pkg::ADDR_CON1, 8'h25);
		bus(1'b1, serial_port_pkg::ADDR_STAT, 8'h03);
		bus(1'b0, serial_port_pkg::ADDR_CON1, 8'h25);
		bus(1'b0, serial_port_pkg::ADDR_STAT, 8'h00);
		idle(3);
		check(irq, 1'b0);
		summarize();
	end
endmodule // serial_port_control_one_bench
`default_nettype wire
